// ---- tcm_current_match.sv ----
// Transformer current matching datapath with restraint control
// Function
// - Winding-2 sets pass amplitude matching, then vector rotation, then zero-sequence removal; winding 1 only the last.
// - Winding-2 currents scale by CT ratio times voltage ratio over one plus tap.
// - Matched winding-2 currents are rotated by the matrix chosen by group code.
// - Even codes give signed phase permutations; 6, 2, 10 negate 0, 8, 4.
// - Odd codes give phase differences over root three; 7, 9, 11 negate 1, 3, 5.
// - Grounded star or zig-zag winding 1 has its zero-sequence current removed.
// - Grounded winding 2 has zero-sequence of rotated currents removed.
// - Transient period starts while differential and restraint are below 5% of base.
// - Exceeded harmonic threshold raises the characteristic by the restraint offset.
// - Second, fourth and fifth harmonic restraint each have their own enable.
// - Transient threshold applies in transient period, steady threshold otherwise.
// - Cross blocking restrains all phases, otherwise only phases with harmonics; saturation hold restrains all phases either way.
// - Enabled saturation check compares currents at each zero crossing.
// - Only external saturation faults raise the characteristic, never internal ones.
// - Hold timer ends stabilization, then one second with no new stabilization.
// - Group code is zero to eleven, each step thirty degrees lag.
// - Tap setting spans minus fifteen to plus fifteen percent.
`timescale 1ns/1ps
module tcm_current_match
  import tcm_pkg::*;
#(
  parameter int CYC_PER_MS = TCM_CYC_PER_MS
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // Sample input
  input wire logic in_valid,
  input wire logic signed [15:0] w1_ia,
  input wire logic signed [15:0] w1_ib,
  input wire logic signed [15:0] w1_ic,
  input wire logic signed [15:0] w2_ia,
  input wire logic signed [15:0] w2_ib,
  input wire logic signed [15:0] w2_ic,
  // Matched output
  output logic out_valid,
  output logic signed [21:0] w1_oa,
  output logic signed [21:0] w1_ob,
  output logic signed [21:0] w1_oc,
  output logic signed [21:0] w2_oa,
  output logic signed [21:0] w2_ob,
  output logic signed [21:0] w2_oc,
  // Restraint evaluation inputs, phase a in the low slice
  input wire logic [47:0] diff_current,
  input wire logic [47:0] restraint_current,
  input wire logic [23:0] h2_content,
  input wire logic [23:0] h4_content,
  input wire logic [23:0] h5_content,
  input wire logic zero_cross,
  // Restraint outputs
  output logic [2:0] phase_restrained,
  output logic [47:0] characteristic_offset,
  output logic transient_active,
  output logic saturation_active
);
  // Configuration registers
  logic [15:0] ctrl_reg;
  logic [15:0] ct_ratio_reg;
  logic [15:0] volt_ratio_reg;
  logic signed [7:0] tap_reg;
  logic [15:0] base_current_reg;
  logic [15:0] h2_thr_reg;
  logic [15:0] h4_thr_reg;
  logic [15:0] h5_thr_reg;
  logic [15:0] offset_reg;
  logic [15:0] trans_ms_reg;
  logic [15:0] sat_hold_ms_reg;
  logic [17:0] factor_reg;
  logic factor_busy_reg;
  logic div_start_reg;
  logic init_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  // Bus decode
  wire bus_req = wb_cyc & wb_stb;
  wire wr_fire = bus_req & wb_we & ack_reg;
  wire [31:0] bmask = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};
  wire sel_ctrl = wb_adr == TCM_OFS_CTRL;
  wire sel_ct = wb_adr == TCM_OFS_CT;
  wire sel_volt = wb_adr == TCM_OFS_VOLT;
  wire sel_tap = wb_adr == TCM_OFS_TAP;
  wire sel_base = wb_adr == TCM_OFS_BASE;
  wire sel_h2 = wb_adr == TCM_OFS_H2;
  wire sel_h4 = wb_adr == TCM_OFS_H4;
  wire sel_h5 = wb_adr == TCM_OFS_H5;
  wire sel_offset = wb_adr == TCM_OFS_OFFSET;
  wire sel_trans = wb_adr == TCM_OFS_TRANS;
  wire sel_sathold = wb_adr == TCM_OFS_SATHOLD;
  wire sel_status = wb_adr == TCM_OFS_STATUS;
  wire sel_factor = wb_adr == TCM_OFS_FACTOR;

  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] dat, input logic [31:0] m);
    merge16 = (old_v & ~m[15:0]) | (dat[15:0] & m[15:0]);
  endfunction

  wire [15:0] ctrl_wr = merge16(ctrl_reg, wb_dat_w, bmask);
  wire ctrl_vg_ok = ctrl_wr[TCM_CTRL_VG_LSB +: 4] <= TCM_VG_MAX;
  wire [15:0] ctrl_next = ctrl_vg_ok ? ctrl_wr : {ctrl_wr[15:4], ctrl_reg[3:0]};
  wire signed [7:0] tap_wr = wb_sel[0] ? wb_dat_w[7:0] : tap_reg;
  wire signed [7:0] tap_next = tap_wr > TCM_TAP_MAX ? TCM_TAP_MAX :
                               tap_wr < TCM_TAP_MIN ? TCM_TAP_MIN : tap_wr;

  // Control fields
  wire [3:0] vg_code = ctrl_reg[TCM_CTRL_VG_LSB +: 4];
  wire [2:0] w1_scheme = ctrl_reg[TCM_CTRL_W1_LSB +: 3];
  wire [2:0] w2_scheme = ctrl_reg[TCM_CTRL_W2_LSB +: 3];
  wire h2_en = ctrl_reg[TCM_CTRL_H2EN];
  wire h4_en = ctrl_reg[TCM_CTRL_H4EN];
  wire h5_en = ctrl_reg[TCM_CTRL_H5EN];
  wire xblock_en = ctrl_reg[TCM_CTRL_XBLK];
  wire sat_en = ctrl_reg[TCM_CTRL_SATEN];
  wire w1_grounded = w1_scheme == TCM_SCH_STAR_GND || w1_scheme == TCM_SCH_ZIGZAG_GND;
  wire w2_grounded = w2_scheme == TCM_SCH_STAR_GND || w2_scheme == TCM_SCH_ZIGZAG_GND;

  // Ratio factor: CT ratio times voltage ratio times 100 over (100 + tap)
  wire [31:0] ratio_prod = ct_ratio_reg * volt_ratio_reg;
  wire [38:0] ratio_pct = ratio_prod * TCM_PCT_FULL;
  wire [39:0] div_num = {13'h0, ratio_pct[38:TCM_FRAC_BITS]};
  wire [7:0] div_den = 8'(TCM_PCT_FULL) + tap_reg;
  wire div_done;
  wire [39:0] div_quot;
  wire [17:0] factor_sat = |div_quot[39:18] ? 18'h3ffff : div_quot[17:0];

  tcm_ratio_div u_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(div_start_reg),
    .num(div_num),
    .den(div_den),
    .done(div_done),
    .quot(div_quot)
  );

  // Millisecond tick and timers
  logic [15:0] tick_cnt_reg;
  logic tick_reg;
  logic [15:0] trans_cnt_reg;
  logic [15:0] sat_cnt_reg;
  tcm_sat_t sat_state_reg;
  logic ext_seen_reg;
  logic trans_act_reg;
  logic sat_act_reg;
  wire trans_on = trans_act_reg;
  wire sat_hold = sat_act_reg;

  // Datapath storage, one entry per phase
  wire signed [15:0] w1_in [3] = '{w1_ia, w1_ib, w1_ic};
  wire signed [15:0] w2_in [3] = '{w2_ia, w2_ib, w2_ic};
  logic signed [15:0] w1_s1_reg [3];
  logic signed [15:0] w1_s2_reg [3];
  logic signed [17:0] amp_reg [3];
  logic signed [19:0] rot_reg [3];
  logic signed [21:0] w1_out_reg [3];
  logic signed [21:0] w2_out_reg [3];
  logic [2:0] vld_reg;
  wire signed [19:0] rot_w [3];
  wire [2:0] quiet_ph;
  wire [2:0] ext_ph;
  wire [2:0] harm_ph;
  logic [2:0] restrained_reg;
  logic [15:0] offset_out_reg [3];

  tcm_vector_rot u_rot (
    .code(vg_code),
    .ph_a(amp_reg[0]),
    .ph_b(amp_reg[1]),
    .ph_c(amp_reg[2]),
    .rot_a(rot_w[0]),
    .rot_b(rot_w[1]),
    .rot_c(rot_w[2])
  );

  // Zero-sequence terms
  wire signed [17:0] w1_sum = w1_s2_reg[0] + w1_s2_reg[1] + w1_s2_reg[2];
  wire signed [21:0] w2_sum = rot_reg[0] + rot_reg[1] + rot_reg[2];
  wire signed [35:0] w1_zs_p = w1_sum * $signed({1'b0, TCM_INV_THREE});
  wire signed [39:0] w2_zs_p = w2_sum * $signed({1'b0, TCM_INV_THREE});
  wire signed [21:0] w1_zs = w1_grounded ? 22'(w1_zs_p[35:16]) : 22'h0;
  wire signed [21:0] w2_zs = w2_grounded ? w2_zs_p[37:16] : 22'h0;

  // Steady or transient thresholds
  wire [7:0] h2_thr = trans_on ? h2_thr_reg[TCM_THR_TRANS_LSB +: 8] : h2_thr_reg[7:0];
  wire [7:0] h4_thr = trans_on ? h4_thr_reg[TCM_THR_TRANS_LSB +: 8] : h4_thr_reg[7:0];
  wire [7:0] h5_thr = trans_on ? h5_thr_reg[TCM_THR_TRANS_LSB +: 8] : h5_thr_reg[7:0];
  wire [18:0] quiet_lim = base_current_reg * TCM_QUIET_PCT;
  wire all_quiet = &quiet_ph;
  wire any_harm = |harm_ph;

  genvar i;
  generate
    for (i = 0; i < 3; i++)
    begin : g_ph
      wire [15:0] dif = diff_current[16*i +: 16];
      wire [15:0] res = restraint_current[16*i +: 16];
      wire signed [34:0] amp_p = w2_in[i] * $signed({1'b0, factor_reg});
      wire signed [22:0] amp_q = amp_p[34:TCM_FRAC_BITS];
      wire amp_hi = amp_q > 23'sh01ffff;
      wire amp_lo = amp_q < -23'sh020000;
      wire signed [17:0] amp_s = amp_hi ? 18'h1ffff : amp_lo ? 18'h20000 : amp_q[17:0];
      assign quiet_ph[i] = (dif * TCM_PCT_FULL) < 23'(quiet_lim) &&
                           (res * TCM_PCT_FULL) < 23'(quiet_lim);
      assign ext_ph[i] = !quiet_ph[i] && {1'b0, res} > {dif, 1'b0};
      assign harm_ph[i] = (h2_en && h2_content[8*i +: 8] > h2_thr) ||
                          (h4_en && h4_content[8*i +: 8] > h4_thr) ||
                          (h5_en && h5_content[8*i +: 8] > h5_thr);
      wire restr_next = (xblock_en ? any_harm : harm_ph[i]) || sat_hold;

      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
        begin
          w1_s1_reg[i] <= 16'h0;
          w1_s2_reg[i] <= 16'h0;
          amp_reg[i] <= 18'h0;
          rot_reg[i] <= 20'h0;
          w1_out_reg[i] <= 22'h0;
          w2_out_reg[i] <= 22'h0;
          restrained_reg[i] <= 1'b0;
          offset_out_reg[i] <= 16'h0;
        end
        else
        begin
          if (in_valid)
          begin
            amp_reg[i] <= amp_s;
            w1_s1_reg[i] <= w1_in[i];
          end
          if (vld_reg[0])
          begin
            rot_reg[i] <= rot_w[i];
            w1_s2_reg[i] <= w1_s1_reg[i];
          end
          if (vld_reg[1])
          begin
            w1_out_reg[i] <= 22'(w1_s2_reg[i]) - w1_zs;
            w2_out_reg[i] <= 22'(rot_reg[i]) - w2_zs;
          end
          restrained_reg[i] <= restr_next;
          offset_out_reg[i] <= restr_next ? offset_reg : 16'h0;
        end
      end
    end
  endgenerate

  // Stage valid pipeline
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      vld_reg <= 3'h0;
    else
      vld_reg <= {vld_reg[1:0], in_valid};
  end

  // Register writes and factor recompute
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= TCM_RST_CTRL;
      ct_ratio_reg <= TCM_RST_UNITY;
      volt_ratio_reg <= TCM_RST_UNITY;
      tap_reg <= TCM_RST_TAP;
      base_current_reg <= TCM_RST_BASE;
      h2_thr_reg <= TCM_RST_THR;
      h4_thr_reg <= TCM_RST_THR;
      h5_thr_reg <= TCM_RST_THR;
      offset_reg <= TCM_RST_OFFSET;
      trans_ms_reg <= TCM_RST_TRANS_MS;
      sat_hold_ms_reg <= TCM_RST_SATHOLD_MS;
    end
    else if (wr_fire)
    begin
      if (sel_ctrl)
        ctrl_reg <= ctrl_next;
      if (sel_ct)
        ct_ratio_reg <= merge16(ct_ratio_reg, wb_dat_w, bmask);
      if (sel_volt)
        volt_ratio_reg <= merge16(volt_ratio_reg, wb_dat_w, bmask);
      if (sel_tap)
        tap_reg <= tap_next;
      if (sel_base)
        base_current_reg <= merge16(base_current_reg, wb_dat_w, bmask);
      if (sel_h2)
        h2_thr_reg <= merge16(h2_thr_reg, wb_dat_w, bmask);
      if (sel_h4)
        h4_thr_reg <= merge16(h4_thr_reg, wb_dat_w, bmask);
      if (sel_h5)
        h5_thr_reg <= merge16(h5_thr_reg, wb_dat_w, bmask);
      if (sel_offset)
        offset_reg <= merge16(offset_reg, wb_dat_w, bmask);
      if (sel_trans)
        trans_ms_reg <= merge16(trans_ms_reg, wb_dat_w, bmask);
      if (sel_sathold)
        sat_hold_ms_reg <= merge16(sat_hold_ms_reg, wb_dat_w, bmask);
    end
  end

  // The old factor stays in use until the new quotient is ready
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      init_reg <= 1'b1;
      div_start_reg <= 1'b0;
      factor_busy_reg <= 1'b0;
      factor_reg <= TCM_RST_FACTOR;
    end
    else
    begin
      init_reg <= 1'b0;
      div_start_reg <= init_reg | (wr_fire & (sel_ct | sel_volt | sel_tap));
      if (div_start_reg)
        factor_busy_reg <= 1'b1;
      else if (div_done)
      begin
        factor_busy_reg <= 1'b0;
        factor_reg <= factor_sat;
      end
    end
  end

  // Read path and acknowledge
  wire [31:0] status_w = {24'h0, ext_seen_reg, factor_busy_reg, restrained_reg,
                          sat_state_reg == TCM_SAT_LOCK, sat_hold, trans_on};
  wire [31:0] rd_mux = sel_ctrl ? {16'h0, ctrl_reg} :
                       sel_ct ? {16'h0, ct_ratio_reg} :
                       sel_volt ? {16'h0, volt_ratio_reg} :
                       sel_tap ? {24'h0, tap_reg} :
                       sel_base ? {16'h0, base_current_reg} :
                       sel_h2 ? {16'h0, h2_thr_reg} :
                       sel_h4 ? {16'h0, h4_thr_reg} :
                       sel_h5 ? {16'h0, h5_thr_reg} :
                       sel_offset ? {16'h0, offset_reg} :
                       sel_trans ? {16'h0, trans_ms_reg} :
                       sel_sathold ? {16'h0, sat_hold_ms_reg} :
                       sel_status ? status_w :
                       sel_factor ? {14'h0, factor_reg} : 32'h0;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end
    else
    begin
      ack_reg <= bus_req & ~ack_reg;
      if (bus_req & ~ack_reg & ~wb_we)
        rdata_reg <= rd_mux;
    end
  end

  // Millisecond tick
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt_reg <= 16'h0;
      tick_reg <= 1'b0;
      trans_act_reg <= 1'b0;
    end
    else
    begin
      // Mirrors the transient counter's next value being non-zero
      trans_act_reg <= all_quiet ? trans_ms_reg != 16'h0 : trans_cnt_reg > {15'h0, tick_reg & trans_on};
      tick_reg <= tick_cnt_reg == 16'(CYC_PER_MS - 1);
      tick_cnt_reg <= tick_cnt_reg == 16'(CYC_PER_MS - 1) ? 16'h0 : tick_cnt_reg + 16'h1;
    end
  end

  // Transient period reloads while everything is quiet, then runs down
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      trans_cnt_reg <= 16'h0;
    else if (all_quiet)
      trans_cnt_reg <= trans_ms_reg;
    else if (tick_reg && trans_on)
      trans_cnt_reg <= trans_cnt_reg - 16'h1;
  end

  // Saturation stabilizer
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sat_state_reg <= TCM_SAT_IDLE;
      sat_cnt_reg <= 16'h0;
      ext_seen_reg <= 1'b0;
      sat_act_reg <= 1'b0;
    end
    else if (!sat_en)
    begin
      sat_state_reg <= TCM_SAT_IDLE;
      sat_cnt_reg <= 16'h0;
      sat_act_reg <= 1'b0;
    end
    else
    begin
      if (zero_cross)
        ext_seen_reg <= |ext_ph;
      unique case (sat_state_reg)
        TCM_SAT_IDLE:
          if (zero_cross && |ext_ph)
          begin
            sat_state_reg <= TCM_SAT_HOLD;
            sat_act_reg <= 1'b1;
            sat_cnt_reg <= sat_hold_ms_reg;
          end
        TCM_SAT_HOLD:
          if (sat_cnt_reg == 16'h0)
          begin
            sat_state_reg <= TCM_SAT_LOCK;
            sat_act_reg <= 1'b0;
            sat_cnt_reg <= TCM_LOCKOUT_MS;
          end
          else if (tick_reg)
            sat_cnt_reg <= sat_cnt_reg - 16'h1;
        TCM_SAT_LOCK:
          if (sat_cnt_reg == 16'h0)
            sat_state_reg <= TCM_SAT_IDLE;
          else if (tick_reg)
            sat_cnt_reg <= sat_cnt_reg - 16'h1;
      endcase
    end
  end

  // Outputs
  assign wb_ack = ack_reg;
  assign wb_dat_r = rdata_reg;
  assign out_valid = vld_reg[2];
  assign w1_oa = w1_out_reg[0];
  assign w1_ob = w1_out_reg[1];
  assign w1_oc = w1_out_reg[2];
  assign w2_oa = w2_out_reg[0];
  assign w2_ob = w2_out_reg[1];
  assign w2_oc = w2_out_reg[2];
  assign phase_restrained = restrained_reg;
  assign characteristic_offset = {offset_out_reg[2], offset_out_reg[1], offset_out_reg[0]};
  assign transient_active = trans_act_reg;
  assign saturation_active = sat_act_reg;
endmodule

// ---- tcm_current_match_chk.sv ----
// Port-level assertions for the current matching block
`timescale 1ns/1ps
module tcm_chk (
  // Clock, reset and bus handshake
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_ack,
  // Sample stream
  input wire logic in_valid,
  input wire logic out_valid,
  input wire logic signed [21:0] w2_oa,
  // Restraint
  input wire logic [23:0] h2_content,
  input wire logic [23:0] h4_content,
  input wire logic [23:0] h5_content,
  input wire logic zero_cross,
  input wire logic [2:0] phase_restrained,
  input wire logic [47:0] characteristic_offset,
  input wire logic saturation_active
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_ack_next: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack) else $error("bus request not answered");
  a_ack_drop: assert property (wb_ack |=> !wb_ack) else $error("ack longer than one cycle");
  a_out_latency: assert property (in_valid |-> ##3 out_valid) else $error("output strobe missing");
  a_out_cause: assert property (out_valid |-> $past(in_valid, 3)) else $error("output strobe without input");
  a_out_hold: assert property (!out_valid |-> $stable(w2_oa)) else $error("output changed without strobe");
  a_no_harmonic: assert property (h2_content == 24'h0 && h4_content == 24'h0 && h5_content == 24'h0
    |=> phase_restrained == 3'h0 || saturation_active)
    else $error("restraint without harmonic content");
  a_offset_cause: assert property (characteristic_offset[15:0] != 16'h0
    |-> phase_restrained[0] || saturation_active)
    else $error("offset raised without a restraint");
  a_sat_start: assert property ($rose(saturation_active) |-> $past(zero_cross) || $past(zero_cross, 2))
    else $error("stabilization started away from a zero crossing");
endmodule

bind tcm_current_match tcm_chk u_chk (.*);

// ---- tcm_current_match_tb_top.sv ----
// Self-checking bench for the current matching block
`timescale 1ns/1ps
module tcm_current_match_tb_top;
  import tcm_pkg::*;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0, zero_cross = 1'h0, send = 1'h0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_dat_w = 32'h0, wb_dat_r, r;
  logic wb_ack, in_valid, out_valid, transient_active, saturation_active;
  logic signed [15:0] w1_ia, w1_ib, w1_ic, w2_ia, w2_ib, w2_ic;
  logic signed [21:0] w1_oa, w1_ob, w1_oc, w2_oa, w2_ob, w2_oc;
  logic [47:0] diff_current = 48'h0, restraint_current = 48'h0, characteristic_offset;
  logic [23:0] h2_content = 24'h0, h4_content = 24'h0, h5_content = 24'h0;
  logic [2:0] phase_restrained;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  // Expected winding-2 phases for group code = row, input set (1000, 300, -200)
  int rows [12][3] = '{'{1000, 300, -200}, '{404, 288, -692}, '{-300, 200, -1000}, '{-288, 692, -404},
    '{-200, 1000, 300}, '{-692, 404, 288}, '{-1000, -300, 200}, '{-404, -288, 692},
    '{300, -200, 1000}, '{288, -692, 404}, '{200, -1000, -300}, '{692, -404, -288}};
  assign w2_ia = w1_ia;
  assign w2_ib = w1_ib;
  assign w2_ic = w1_ic;
  tcm_current_match #(.CYC_PER_MS(10)) u_dut (.*);
  tcm_front_model u_fe (.clk_sys(clk_sys), .send(send), .pa(16'sh03e8), .pb(16'sh012c), .pc(-16'sh00c8),
    .in_valid(in_valid), .w1_ia(w1_ia), .w1_ib(w1_ib), .w1_ic(w1_ic));
  initial forever #50 clk_sys = ~clk_sys;

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cmp(input logic signed [47:0] g, input logic signed [47:0] e, input int t);
    logic signed [47:0] d = g - e;
    samples_checked++;
    if (g !== e && ($isunknown(g) || d > t || d < -t))
    begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_w <= d;
    do @(posedge clk_sys); while (wb_ack !== 1'h1);
    r = wb_dat_r;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    @(posedge clk_sys);
  endtask

  task automatic st;
    send <= 1'h1;
    @(posedge clk_sys);
    send <= 1'h0;
    do @(posedge clk_sys); while (out_valid !== 1'h1);
  endtask

  always @(posedge clk_sys)
    if (++cycles == 5000)
    begin
      miscompares++;
      conclude();
    end

  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'h0;
    @(posedge clk_sys);
    wb(1'h1, TCM_OFS_TRANS, 32'h2);
    for (int k = 0; k < 12; k++)
    begin
      wb(1'h1, TCM_OFS_CTRL, 32'(k));
      st();
      cmp(w1_oa, 1000, 0);
      cmp(w2_oa, rows[k][0], 1);
      cmp(w2_ob, rows[k][1], 1);
      cmp(w2_oc, rows[k][2], 1);
    end
    wb(1'h1, TCM_OFS_CTRL, 32'hc);
    wb(1'h0, TCM_OFS_CTRL, 32'h0);
    cmp(r, 32'hb, 0);
    wb(1'h1, TCM_OFS_CTRL, 32'h1b0);
    st();
    cmp(w1_oa, 634, 1);
    cmp(w2_oc, -566, 1);
    wb(1'h1, TCM_OFS_CTRL, 32'h244);
    st();
    cmp(w1_oa, 634, 1);
    cmp(w2_oa, -566, 1);
    wb(1'h1, TCM_OFS_CTRL, 32'h0);
    wb(1'h1, TCM_OFS_CT, 32'h2000);
    wb(1'h1, TCM_OFS_TAP, 32'h20);
    wb(1'h0, TCM_OFS_TAP, 32'h0);
    cmp(r, 32'hf, 0);
    do wb(1'h0, TCM_OFS_STATUS, 32'h0); while (r[6] !== 1'h0);
    wb(1'h0, TCM_OFS_FACTOR, 32'h0);
    cmp(r, 7123, 1);
    st();
    cmp(w2_oa, 1739, 2);
    wb(1'h1, TCM_OFS_OFFSET, 32'h8);
    diff_current <= {3{16'h0fff}};
    restraint_current <= {3{16'h0fff}};
    h2_content <= 24'h40;
    wb(1'h1, TCM_OFS_CTRL, 32'h400);
    while (transient_active !== 1'h0) @(posedge clk_sys);
    @(posedge clk_sys);
    cmp(phase_restrained, 3'h1, 0);
    cmp(characteristic_offset, 48'h8, 0);
    wb(1'h1, TCM_OFS_CTRL, 32'h2400);
    @(posedge clk_sys);
    cmp(phase_restrained, 3'h7, 0);
    wb(1'h1, TCM_OFS_CTRL, 32'h2800);
    @(posedge clk_sys);
    cmp(phase_restrained, 3'h0, 0);
    h2_content <= 24'h14;
    wb(1'h1, TCM_OFS_CTRL, 32'h400);
    @(posedge clk_sys);
    cmp(phase_restrained, 3'h0, 0);
    diff_current <= 48'h0;
    restraint_current <= 48'h0;
    repeat (3) @(posedge clk_sys);
    cmp(transient_active, 1'h1, 0);
    cmp(phase_restrained, 3'h1, 0);
    h2_content <= 24'h0;
    wb(1'h1, TCM_OFS_CTRL, 32'h4000);
    restraint_current <= {3{16'h0400}};
    diff_current <= {3{16'h0010}};
    zero_cross <= 1'h1;
    @(posedge clk_sys);
    zero_cross <= 1'h0;
    repeat (2) @(posedge clk_sys);
    cmp(saturation_active, 1'h1, 0);
    cmp(characteristic_offset[15:0], 16'h8, 0);
    rst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'h0;
    wb(1'h0, TCM_OFS_CTRL, 32'h0);
    cmp(r, TCM_RST_CTRL, 0);
    wb(1'h0, TCM_OFS_FACTOR, 32'h0);
    cmp(r, TCM_RST_FACTOR, 0);
    wb(1'h0, 8'hfc, 32'h0);
    cmp(r, 32'h0, 0);
    conclude();
  end
endmodule

// ---- tcm_front_model.sv ----
// Measurement front end model handing over three-phase sets
`timescale 1ns/1ps
module tcm_front_model (
  // Clock and request
  input wire logic clk_sys,
  input wire logic send,
  input wire logic signed [15:0] pa,
  input wire logic signed [15:0] pb,
  input wire logic signed [15:0] pc,
  // Sample stream
  output logic in_valid = 1'h0,
  output logic signed [15:0] w1_ia = 16'h0,
  output logic signed [15:0] w1_ib = 16'h0,
  output logic signed [15:0] w1_ic = 16'h0
);
  // Between strobes the lines toggle so stale data never passes for a set
  always @(posedge clk_sys)
  begin
    in_valid <= send;
    w1_ia <= send ? pa : ~w1_ia;
    w1_ib <= send ? pb : ~w1_ib;
    w1_ic <= send ? pc : ~w1_ic;
  end
endmodule

// ---- tcm_pkg.sv ----
// Constants and types for transformer current matching
package tcm_pkg;
  localparam int TCM_CLK_HZ = 10_000_000;
  localparam int TCM_MS_PER_S = 1000;
  localparam int TCM_CYC_PER_MS = TCM_CLK_HZ / TCM_MS_PER_S;
  localparam logic [15:0] TCM_LOCKOUT_MS = 16'h03e8;
  localparam logic [5:0] TCM_DIV_STEPS = 6'h28;
  // Register byte offsets
  localparam logic [7:0] TCM_OFS_CTRL = 8'h00;
  localparam logic [7:0] TCM_OFS_CT = 8'h04;
  localparam logic [7:0] TCM_OFS_VOLT = 8'h08;
  localparam logic [7:0] TCM_OFS_TAP = 8'h0c;
  localparam logic [7:0] TCM_OFS_BASE = 8'h10;
  localparam logic [7:0] TCM_OFS_H2 = 8'h14;
  localparam logic [7:0] TCM_OFS_H4 = 8'h18;
  localparam logic [7:0] TCM_OFS_H5 = 8'h1c;
  localparam logic [7:0] TCM_OFS_OFFSET = 8'h20;
  localparam logic [7:0] TCM_OFS_TRANS = 8'h24;
  localparam logic [7:0] TCM_OFS_SATHOLD = 8'h28;
  localparam logic [7:0] TCM_OFS_STATUS = 8'h2c;
  localparam logic [7:0] TCM_OFS_FACTOR = 8'h30;
  // Control and threshold field positions
  localparam int TCM_CTRL_VG_LSB = 0;
  localparam int TCM_CTRL_W1_LSB = 4;
  localparam int TCM_CTRL_W2_LSB = 7;
  localparam int TCM_CTRL_H2EN = 10;
  localparam int TCM_CTRL_H4EN = 11;
  localparam int TCM_CTRL_H5EN = 12;
  localparam int TCM_CTRL_XBLK = 13;
  localparam int TCM_CTRL_SATEN = 14;
  localparam int TCM_THR_TRANS_LSB = 8;
  // Winding scheme codes
  localparam logic [2:0] TCM_SCH_STAR = 3'h0;
  localparam logic [2:0] TCM_SCH_DELTA = 3'h1;
  localparam logic [2:0] TCM_SCH_ZIGZAG = 3'h2;
  localparam logic [2:0] TCM_SCH_STAR_GND = 3'h3;
  localparam logic [2:0] TCM_SCH_ZIGZAG_GND = 3'h4;
  // Reset values
  localparam logic [15:0] TCM_RST_CTRL = 16'h0000;
  localparam logic [15:0] TCM_RST_UNITY = 16'h1000;
  localparam logic [17:0] TCM_RST_FACTOR = 18'h01000;
  localparam logic [7:0] TCM_RST_TAP = 8'h00;
  localparam logic [15:0] TCM_RST_BASE = 16'h0100;
  localparam logic [15:0] TCM_RST_THR = 16'h0f1e;
  localparam logic [15:0] TCM_RST_OFFSET = 16'h0000;
  localparam logic [15:0] TCM_RST_TRANS_MS = 16'h07d0;
  localparam logic [15:0] TCM_RST_SATHOLD_MS = 16'h012c;
  // Arithmetic constants
  localparam logic [3:0] TCM_VG_MAX = 4'hb;
  localparam logic signed [7:0] TCM_TAP_MAX = 8'sh0f;
  localparam logic signed [7:0] TCM_TAP_MIN = -8'sh0f;
  localparam logic [6:0] TCM_PCT_FULL = 7'h64;
  localparam logic [2:0] TCM_QUIET_PCT = 3'h5;
  localparam int TCM_FRAC_BITS = 12;
  localparam logic [16:0] TCM_INV_SQRT3 = 17'h093cd;
  localparam logic [16:0] TCM_INV_THREE = 17'h05555;
  typedef enum logic [1:0] {TCM_SAT_IDLE, TCM_SAT_HOLD, TCM_SAT_LOCK} tcm_sat_t;
endpackage

// ---- tcm_ratio_div.sv ----
// Serial restoring divider for the winding-2 ratio factor
`timescale 1ns/1ps
module tcm_ratio_div
  import tcm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Request
  input wire logic start,
  input wire logic [39:0] num,
  input wire logic [7:0] den,
  // Result
  output logic done,
  output logic [39:0] quot
);
  logic [39:0] quo_reg;
  logic [7:0] rem_reg;
  logic [7:0] den_reg;
  logic [5:0] cnt_reg;
  logic done_reg;
  wire [8:0] trial = {rem_reg, quo_reg[39]};
  wire take = trial >= {1'b0, den_reg};
  wire [8:0] rem_next = take ? trial - {1'b0, den_reg} : trial;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      quo_reg <= 40'h0;
      rem_reg <= 8'h0;
      den_reg <= 8'h1;
      cnt_reg <= 6'h0;
      done_reg <= 1'b0;
    end
    else if (start)
    begin
      quo_reg <= num;
      rem_reg <= 8'h0;
      den_reg <= den;
      cnt_reg <= TCM_DIV_STEPS;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= cnt_reg == 6'h1;
      if (cnt_reg != 6'h0)
      begin
        quo_reg <= {quo_reg[38:0], take};
        rem_reg <= rem_next[7:0];
        cnt_reg <= cnt_reg - 6'h1;
      end
    end
  end

  assign done = done_reg;
  assign quot = quo_reg;
endmodule

// ---- tcm_vector_rot.sv ----
// Vector group matrix applied to one three-phase set
`timescale 1ns/1ps
module tcm_vector_rot
  import tcm_pkg::*;
(
  // Group code
  input wire logic [3:0] code,
  // Amplitude-matched phases
  input wire logic signed [17:0] ph_a,
  input wire logic signed [17:0] ph_b,
  input wire logic signed [17:0] ph_c,
  // Rotated phases
  output logic signed [19:0] rot_a,
  output logic signed [19:0] rot_b,
  output logic signed [19:0] rot_c
);
  logic signed [18:0] src [3];
  logic signed [19:0] scl [3];
  logic signed [19:0] x0;
  logic signed [19:0] x1;
  logic signed [19:0] x2;
  wire odd = code[0];
  wire neg = code[1];
  wire [2:0] half = code[3:1];
  wire signed [17:0] in_ph [3] = '{ph_a, ph_b, ph_c};

  genvar i;
  generate
    for (i = 0; i < 3; i++)
    begin : g_ph
      // Odd groups take phase differences scaled by one over root three
      wire signed [18:0] dif = in_ph[i] - in_ph[(i + 1) % 3];
      wire signed [35:0] prod = dif * $signed({1'b0, TCM_INV_SQRT3});
      assign src[i] = odd ? dif : 19'(in_ph[i]);
      assign scl[i] = odd ? prod[35:16] : 20'(src[i]);
    end
  endgenerate

  always_comb
  begin
    unique case (half)
      3'h0, 3'h3:
      begin
        x0 = scl[0];
        x1 = scl[1];
        x2 = scl[2];
      end
      3'h1, 3'h4:
      begin
        x0 = scl[1];
        x1 = scl[2];
        x2 = scl[0];
      end
      default:
      begin
        x0 = scl[2];
        x1 = scl[0];
        x2 = scl[1];
      end
    endcase
  end

  assign rot_a = neg ? -x0 : x0;
  assign rot_b = neg ? -x1 : x1;
  assign rot_c = neg ? -x2 : x2;
endmodule
